/* irt_timer_pair.sv */
// Infrared timer pair: 8-bit short timer, 16-bit long timer, AXI4-Lite registers.
// Assumes one clock aclk and a single AXI4-Lite master.
`timescale 1ns/1ns
module irt_timer_pair
   import irt_pkg::*;
(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Pins
   input wire logic edge_input_a,
   input wire logic edge_input_b,
   output logic short_timer_output,
   output logic long_timer_output,
   output logic combined_output,
   // Interrupt requests
   output logic long_timer_request,
   output logic short_timer_request
);
   logic [7:0] short_ctrl_q, cfg_q, long_ctrl_q, short_reload_q;
   logic [7:0] long_reload_low_q, long_reload_high_q, capture_low_q, capture_high_q;
   logic [7:0] aw_q;
   logic aw_have_q, w_have_q;
   logic [31:0] w_q;
   logic [3:0] ws_q;
   logic [7:0] short_cnt_q;
   logic [15:0] long_cnt_q;
   logic short_run_q, long_run_q, demod_armed_q;
   logic short_out_q, long_out_q;
   logic pp_turn_q;
   logic pos_edge, neg_edge, edge_hit;
   logic wr_fire, short_tc, long_tc;
   logic demod;
   logic [1:0] sub, logic_sel;
   logic [7:0] wbyte;

   assign demod = cfg_q[IRT_BIT_MODE];
   assign sub = cfg_q[IRT_BIT_SUB_LO +: 2];
   assign logic_sel = cfg_q[IRT_BIT_LOGIC_LO +: 2];

   function automatic logic hits(input logic [7:0] a, input logic [7:0] off);
      hits = (a[7:2] == off[7:2]);
   endfunction

   function automatic logic mapped(input logic [7:0] a);
      mapped = hits(a, IRT_OFF_SHORT_CTRL) || hits(a, IRT_OFF_CONFIG) ||
         hits(a, IRT_OFF_LONG_CTRL) || hits(a, IRT_OFF_PAIR_CTRL) ||
         hits(a, IRT_OFF_SHORT_RELOAD) || hits(a, IRT_OFF_LONG_RELOAD_LOW) ||
         hits(a, IRT_OFF_LONG_RELOAD_HIGH) || hits(a, IRT_OFF_CAPTURE_LOW) ||
         hits(a, IRT_OFF_CAPTURE_HIGH);
   endfunction

   // Write channel capture, either order
   assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
   assign s_axi_wready = !w_have_q && !s_axi_bvalid;
   assign wr_fire = aw_have_q && w_have_q;
   assign wbyte = ws_q[0] ? w_q[7:0] : 8'h00;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_q <= 1'b0;
         w_have_q <= 1'b0;
         aw_q <= 8'h00;
         w_q <= 32'h0;
         ws_q <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= IRT_RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have_q <= 1'b1;
            aw_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have_q <= 1'b1;
            w_q <= s_axi_wdata;
            ws_q <= s_axi_wstrb;
         end
         if (wr_fire) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= mapped(aw_q) ? IRT_RESP_OKAY : IRT_RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Read channel
   assign s_axi_arready = !s_axi_rvalid;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= IRT_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= mapped(s_axi_araddr) ? IRT_RESP_OKAY : IRT_RESP_SLVERR;
         s_axi_rdata <= 32'h0;
         if (hits(s_axi_araddr, IRT_OFF_SHORT_CTRL)) s_axi_rdata[7:0] <= short_ctrl_q;
         if (hits(s_axi_araddr, IRT_OFF_CONFIG)) s_axi_rdata[7:0] <= cfg_q;
         if (hits(s_axi_araddr, IRT_OFF_LONG_CTRL)) s_axi_rdata[7:0] <= long_ctrl_q;
         if (hits(s_axi_araddr, IRT_OFF_PAIR_CTRL)) begin
            s_axi_rdata[7:0] <= {long_ctrl_q[IRT_BIT_EN], short_ctrl_q[IRT_BIT_EN],
               1'b0, IRT_PAIR_RSVD};
         end
         if (hits(s_axi_araddr, IRT_OFF_SHORT_RELOAD)) s_axi_rdata[7:0] <= short_reload_q;
         if (hits(s_axi_araddr, IRT_OFF_LONG_RELOAD_LOW)) s_axi_rdata[7:0] <= long_reload_low_q;
         if (hits(s_axi_araddr, IRT_OFF_LONG_RELOAD_HIGH)) begin
            s_axi_rdata[7:0] <= long_reload_high_q;
         end
         if (hits(s_axi_araddr, IRT_OFF_CAPTURE_LOW)) s_axi_rdata[7:0] <= capture_low_q;
         if (hits(s_axi_araddr, IRT_OFF_CAPTURE_HIGH)) s_axi_rdata[7:0] <= capture_high_q;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // Input circuit, pin chosen by config bit 7
   irt_edge_filter u_filter (
      .aclk(aclk),
      .aresetn(aresetn),
      .pin_in(cfg_q[IRT_BIT_INSEL] ? edge_input_b : edge_input_a),
      .width_sel(sub),
      .edge_sel(logic_sel),
      .pos_edge(pos_edge),
      .neg_edge(neg_edge)
   );
   assign edge_hit = demod && long_ctrl_q[IRT_BIT_EN] && (pos_edge || neg_edge);

   assign long_tc = !demod && long_run_q && long_cnt_q == 16'h0001;
   assign short_tc = !demod && short_run_q && short_cnt_q == 8'h01;

   // Configuration and edge flags
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cfg_q <= IRT_RST_REG;
         short_reload_q <= IRT_RST_REG;
         long_reload_low_q <= IRT_RST_REG;
         long_reload_high_q <= IRT_RST_REG;
      end else begin
         if (wr_fire && ws_q[0]) begin
            if (hits(aw_q, IRT_OFF_SHORT_RELOAD)) short_reload_q <= wbyte;
            if (hits(aw_q, IRT_OFF_LONG_RELOAD_LOW)) long_reload_low_q <= wbyte;
            if (hits(aw_q, IRT_OFF_LONG_RELOAD_HIGH)) long_reload_high_q <= wbyte;
         end
         if (wr_fire && ws_q[0] && hits(aw_q, IRT_OFF_CONFIG)) begin
            cfg_q[7:2] <= wbyte[7:2];
            if (!demod) cfg_q[1:0] <= wbyte[1:0];
            else cfg_q[1:0] <= cfg_q[1:0] & ~wbyte[1:0];
         end
         if (demod && !(wr_fire && hits(aw_q, IRT_OFF_CONFIG) && !wbyte[IRT_BIT_MODE])) begin
            if (pos_edge && !(wr_fire && ws_q[0] && hits(aw_q, IRT_OFF_CONFIG) && wbyte[1])) begin
               cfg_q[IRT_BIT_INIT_SHORT] <= 1'b1;
            end
            if (neg_edge && !(wr_fire && ws_q[0] && hits(aw_q, IRT_OFF_CONFIG) && wbyte[0])) begin
               cfg_q[IRT_BIT_INIT_LONG] <= 1'b1;
            end
         end
      end
   end

   // Control registers, hardware enable toggling and timeout bits
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         short_ctrl_q <= IRT_RST_REG;
         long_ctrl_q <= IRT_RST_REG;
         pp_turn_q <= 1'b0;
      end else begin
         if (wr_fire && ws_q[0]) begin
            if (hits(aw_q, IRT_OFF_SHORT_CTRL)) short_ctrl_q <= wbyte;
            if (hits(aw_q, IRT_OFF_LONG_CTRL)) long_ctrl_q <= wbyte;
            if (hits(aw_q, IRT_OFF_PAIR_CTRL)) begin
               short_ctrl_q[IRT_BIT_EN] <= wbyte[6];
               long_ctrl_q[IRT_BIT_EN] <= wbyte[7];
            end
         end
         if (!demod && sub == IRT_SUB_PINGPONG) begin
            if (short_tc) begin
               short_ctrl_q[IRT_BIT_TIMEOUT] <= 1'b1;
               short_ctrl_q[IRT_BIT_EN] <= 1'b0;
               long_ctrl_q[IRT_BIT_EN] <= 1'b1;
               pp_turn_q <= 1'b1;
            end
            if (long_tc) begin
               long_ctrl_q[IRT_BIT_TIMEOUT] <= 1'b1;
               long_ctrl_q[IRT_BIT_EN] <= 1'b0;
               short_ctrl_q[IRT_BIT_EN] <= 1'b1;
               pp_turn_q <= 1'b0;
            end
         end else begin
            if (short_tc) short_ctrl_q[IRT_BIT_TIMEOUT] <= 1'b1;
            if (long_tc) long_ctrl_q[IRT_BIT_TIMEOUT] <= 1'b1;
         end
      end
   end

   // Short timer counter and output
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         short_run_q <= 1'b0;
         short_cnt_q <= 8'h00;
         short_out_q <= 1'b1;
      end else if (!short_ctrl_q[IRT_BIT_EN] || demod) begin
         short_run_q <= 1'b0;
         short_out_q <= !cfg_q[IRT_BIT_INIT_SHORT];
      end else if (!short_run_q) begin
         short_run_q <= 1'b1;
         short_cnt_q <= short_reload_q;
         short_out_q <= cfg_q[IRT_BIT_INIT_SHORT];
      end else if (short_tc) begin
         short_cnt_q <= short_reload_q;
         short_out_q <= !short_out_q;
      end else begin
         short_cnt_q <= short_cnt_q - 8'h01;
      end
   end

   // Long timer counter, output and demodulation capture
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         long_run_q <= 1'b0;
         demod_armed_q <= 1'b0;
         long_cnt_q <= 16'h0000;
         long_out_q <= 1'b1;
         capture_low_q <= IRT_RST_REG;
         capture_high_q <= IRT_RST_REG;
      end else if (!long_ctrl_q[IRT_BIT_EN]) begin
         long_run_q <= 1'b0;
         demod_armed_q <= 1'b0;
         if (!sub[1]) long_out_q <= !cfg_q[IRT_BIT_INIT_LONG];
      end else if (demod) begin
         long_run_q <= 1'b0;
         if (edge_hit) begin
            demod_armed_q <= 1'b1;
            if (demod_armed_q && !long_ctrl_q[IRT_BIT_CAPMODE]) begin
               {capture_high_q, capture_low_q} <= ~long_cnt_q;
               long_cnt_q <= IRT_LONG_ALL_ONES;
            end else if (!demod_armed_q) begin
               {capture_high_q, capture_low_q} <= ~long_cnt_q;
               long_cnt_q <= {long_reload_high_q, long_reload_low_q};
            end
         end else if (demod_armed_q) begin
            long_cnt_q <= long_cnt_q - 16'h0001;
         end
      end else if (!long_run_q) begin
         long_run_q <= 1'b1;
         long_cnt_q <= {long_reload_high_q, long_reload_low_q};
         if (!sub[1]) long_out_q <= cfg_q[IRT_BIT_INIT_LONG];
      end else if (long_tc) begin
         long_cnt_q <= {long_reload_high_q, long_reload_low_q};
         if (!sub[1]) long_out_q <= !long_out_q;
      end else begin
         long_cnt_q <= long_cnt_q - 16'h0001;
      end
   end

   always_comb begin
      case (sub)
         IRT_SUB_FORCE0: long_timer_output = demod ? long_out_q : 1'b0;
         IRT_SUB_FORCE1: long_timer_output = demod ? long_out_q : 1'b1;
         default: long_timer_output = long_out_q;
      endcase
   end
   assign short_timer_output = short_out_q;

   always_comb begin
      case (logic_sel)
         2'h0: combined_output = short_out_q & long_timer_output;
         2'h1: combined_output = short_out_q | long_timer_output;
         2'h2: combined_output = ~(short_out_q | long_timer_output);
         default: combined_output = ~(short_out_q & long_timer_output);
      endcase
   end

   assign long_timer_request = long_ctrl_q[IRT_BIT_IRQEN] &&
      (long_tc || (edge_hit && demod_armed_q));
   assign short_timer_request = short_ctrl_q[IRT_BIT_IRQEN] && short_tc;

   property p_reset_clear;
      @(posedge aclk) !aresetn |=> !short_ctrl_q[IRT_BIT_EN] && !long_ctrl_q[IRT_BIT_EN];
   endproperty
   a_reset_clear: assert property (p_reset_clear) else $error("enable not cleared");

   property p_short_disabled;
      @(posedge aclk) disable iff (!aresetn)
         !short_ctrl_q[IRT_BIT_EN] ##1 !short_ctrl_q[IRT_BIT_EN] |->
         short_out_q == !$past(cfg_q[IRT_BIT_INIT_SHORT]);
   endproperty
   a_short_disabled: assert property (p_short_disabled) else $error("short idle level");

   property p_force;
      @(posedge aclk) disable iff (!aresetn)
         !demod && sub == IRT_SUB_FORCE1 |-> long_timer_output;
   endproperty
   a_force: assert property (p_force) else $error("long not forced high");

   property p_pp_alt;
      @(posedge aclk) disable iff (!aresetn)
         short_tc && !demod && sub == IRT_SUB_PINGPONG && !wr_fire |=>
         long_ctrl_q[IRT_BIT_EN] && !short_ctrl_q[IRT_BIT_EN];
   endproperty
   a_pp_alt: assert property (p_pp_alt) else $error("alternating_submode not alternating");

   property p_capture;
      @(posedge aclk) disable iff (!aresetn)
         edge_hit && demod_armed_q && !long_ctrl_q[IRT_BIT_CAPMODE] |=>
         {capture_high_q, capture_low_q} == ~$past(long_cnt_q) &&
         long_cnt_q == IRT_LONG_ALL_ONES;
   endproperty
   a_capture: assert property (p_capture) else $error("capture wrong");
endmodule

/* irt_pkg.sv */
// Package for the infrared timer pair: register offsets, field positions, reset values.
// Assumes a 32-bit AXI4-Lite slave with one register per aligned word.
package irt_pkg;
   // Register indices; each register sits at four times its index
   localparam logic [5:0] IRT_IDX_SHORT_CTRL = 6'h00;
   localparam logic [5:0] IRT_IDX_CONFIG = 6'h01;
   localparam logic [5:0] IRT_IDX_LONG_CTRL = 6'h02;
   localparam logic [5:0] IRT_IDX_PAIR_CTRL = 6'h03;
   localparam logic [5:0] IRT_IDX_SHORT_RELOAD = 6'h04;
   localparam logic [5:0] IRT_IDX_LONG_RELOAD_LOW = 6'h06;
   localparam logic [5:0] IRT_IDX_LONG_RELOAD_HIGH = 6'h07;
   localparam logic [5:0] IRT_IDX_CAPTURE_LOW = 6'h08;
   localparam logic [5:0] IRT_IDX_CAPTURE_HIGH = 6'h09;
   localparam logic [7:0] IRT_OFF_SHORT_CTRL = {IRT_IDX_SHORT_CTRL, 2'b00};
   localparam logic [7:0] IRT_OFF_CONFIG = {IRT_IDX_CONFIG, 2'b00};
   localparam logic [7:0] IRT_OFF_LONG_CTRL = {IRT_IDX_LONG_CTRL, 2'b00};
   localparam logic [7:0] IRT_OFF_PAIR_CTRL = {IRT_IDX_PAIR_CTRL, 2'b00};
   localparam logic [7:0] IRT_OFF_SHORT_RELOAD = {IRT_IDX_SHORT_RELOAD, 2'b00};
   localparam logic [7:0] IRT_OFF_LONG_RELOAD_LOW = {IRT_IDX_LONG_RELOAD_LOW, 2'b00};
   localparam logic [7:0] IRT_OFF_LONG_RELOAD_HIGH = {IRT_IDX_LONG_RELOAD_HIGH, 2'b00};
   localparam logic [7:0] IRT_OFF_CAPTURE_LOW = {IRT_IDX_CAPTURE_LOW, 2'b00};
   localparam logic [7:0] IRT_OFF_CAPTURE_HIGH = {IRT_IDX_CAPTURE_HIGH, 2'b00};
   // Field positions
   localparam int IRT_BIT_EN = 7;
   localparam int IRT_BIT_CAPMODE = 6;
   localparam int IRT_BIT_TIMEOUT = 5;
   localparam int IRT_BIT_IRQEN = 2;
   localparam int IRT_BIT_MODE = 6;
   localparam int IRT_BIT_INSEL = 7;
   localparam int IRT_BIT_LOGIC_LO = 4;
   localparam int IRT_BIT_SUB_LO = 2;
   localparam int IRT_BIT_INIT_SHORT = 1;
   localparam int IRT_BIT_INIT_LONG = 0;
   localparam logic [7:0] IRT_RST_REG = 8'h00;
   localparam logic [4:0] IRT_PAIR_RSVD = 5'h1f;
   localparam logic [15:0] IRT_LONG_ALL_ONES = 16'hffff;
   localparam logic [1:0] IRT_RESP_OKAY = 2'h0;
   localparam logic [1:0] IRT_RESP_SLVERR = 2'h2;
   localparam logic [1:0] IRT_SUB_PINGPONG = 2'h0;
   localparam logic [1:0] IRT_SUB_NORMAL = 2'h1;
   localparam logic [1:0] IRT_SUB_FORCE0 = 2'h2;
   localparam logic [1:0] IRT_SUB_FORCE1 = 2'h3;
   localparam logic [1:0] IRT_EDGE_RISE = 2'h0;
   localparam logic [1:0] IRT_EDGE_FALL = 2'h1;
   // Glitch filter widths in clocks for submode codes 0..3
   localparam logic [3:0] IRT_FILT_W0 = 4'h1;
   localparam logic [3:0] IRT_FILT_W1 = 4'h2;
   localparam logic [3:0] IRT_FILT_W2 = 4'h4;
   localparam logic [3:0] IRT_FILT_W3 = 4'h8;
endpackage

/* irt_edge_filter.sv */
// Input circuit: synchroniser, glitch filter and edge detector.
// Assumes the input pin is asynchronous to aclk.
`timescale 1ns/1ns
module irt_edge_filter
   import irt_pkg::*;
(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Pin and settings
   input wire logic pin_in,
   input wire logic [1:0] width_sel,
   input wire logic [1:0] edge_sel,
   // Edge pulses
   output logic pos_edge,
   output logic neg_edge
);
   logic sync1_q, sync2_q, filt_q;
   logic [3:0] cnt_q;
   logic [3:0] need;

   function automatic logic [3:0] width_of(input logic [1:0] s);
      case (s)
         2'h0: width_of = IRT_FILT_W0;
         2'h1: width_of = IRT_FILT_W1;
         2'h2: width_of = IRT_FILT_W2;
         default: width_of = IRT_FILT_W3;
      endcase
   endfunction

   assign need = width_of(width_sel);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sync1_q <= 1'b0;
         sync2_q <= 1'b0;
      end else begin
         sync1_q <= pin_in;
         sync2_q <= sync1_q;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         filt_q <= 1'b0;
         cnt_q <= 4'h0;
      end else if (sync2_q == filt_q) begin
         cnt_q <= 4'h0;
      end else if (cnt_q + 4'h1 >= need) begin
         filt_q <= sync2_q;
         cnt_q <= 4'h0;
      end else begin
         cnt_q <= cnt_q + 4'h1;
      end
   end

   always_comb begin
      pos_edge = 1'b0;
      neg_edge = 1'b0;
      if (aresetn && sync2_q != filt_q && cnt_q + 4'h1 >= need) begin
         pos_edge = sync2_q && (edge_sel != IRT_EDGE_FALL);
         neg_edge = !sync2_q && (edge_sel != IRT_EDGE_RISE);
      end
   end

   // rising pulse moves the filtered level high
   property p_rise_level;
      @(posedge aclk) disable iff (!aresetn) pos_edge |=> filt_q;
   endproperty
   a_rise_level: assert property (p_rise_level) else $error("rising pulse without high level");
endmodule

/* irt_pin_source.sv */
// Receiver-side pin model: drives the demodulated input and an unselected second pin.
// Assumes aclk is the timer clock; pulses are launched just after rising edges.
`timescale 1ns/1ns
module irt_pin_source (
   // Clock
   input wire logic aclk,
   // Pins
   output logic pin_a,
   output logic pin_b
);
   initial begin
      pin_a = 1'b0;
      pin_b = 1'b0;
   end
   // Unselected pin toggles every cycle so a wrong input select shows up
   always @(posedge aclk) begin
      pin_b <= ~pin_b;
   end
   // High pulse of hi cycles, then low for gap cycles
   task automatic pulse(input int hi, input int gap);
      @(posedge aclk);
      pin_a <= 1'b1;
      repeat (hi) @(posedge aclk);
      pin_a <= 1'b0;
      repeat (gap) @(posedge aclk);
   endtask
endmodule

/* irt_timer_pair_tb.sv */
// Testbench for the infrared timer pair: AXI4-Lite register tests and pin checks.
// Assumes the pin model drives the edge inputs; bready and rready stay high.
`timescale 1ns/1ns
module irt_timer_pair_tb
   import irt_pkg::*;
;
   logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [7:0] s_axi_awaddr, s_axi_araddr, cfg;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, resp, fl;
   logic pin_a, pin_b, short_out, long_out, comb_out, long_req, short_req, l, c;
   logic [15:0] cap;
   int errors = 0, checked = 0, long_reqs = 0, short_reqs = 0, n0, n1;

   irt_timer_pair DUT (
      .aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
      .edge_input_a(pin_a), .edge_input_b(pin_b), .short_timer_output(short_out),
      .long_timer_output(long_out), .combined_output(comb_out),
      .long_timer_request(long_req), .short_timer_request(short_req)
   );
   irt_pin_source u_pins (.aclk(aclk), .pin_a(pin_a), .pin_b(pin_b));

   initial begin
      aclk = 1'b0;
      forever #25 aclk = ~aclk;
   end
   always @(posedge aclk) begin
      if (long_req === 1'b1) begin
         long_reqs <= long_reqs + 1;
      end
      if (short_req === 1'b1) begin
         short_reqs <= short_reqs + 1;
      end
   end

   task automatic test_done();
      $display("counts: %0d compares, %0d mismatches", checked, errors);
      if (errors == 0 && checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
         errors++;
      end
   endtask
   // Write: address and data offered together, each released when taken
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic aw_ok, w_ok;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h000000, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      while (!(aw_ok && w_ok)) begin
         @(posedge aclk);
         if (s_axi_awvalid === 1'b1 && s_axi_awready === 1'b1) begin
            aw_ok = 1'b1;
            s_axi_awvalid <= 1'b0;
         end
         if (s_axi_wvalid === 1'b1 && s_axi_wready === 1'b1) begin
            w_ok = 1'b1;
            s_axi_wvalid <= 1'b0;
         end
      end
      do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
      resp = s_axi_bresp;
   endtask
   task automatic rd_reg(input logic [7:0] a);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do @(posedge aclk); while (!(s_axi_arvalid === 1'b1 && s_axi_arready === 1'b1));
      s_axi_arvalid <= 1'b0;
      do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
      rd = s_axi_rdata;
      resp = s_axi_rresp;
   endtask
   task automatic rchk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
      rd_reg(a);
      chk(rd & {24'h000000, m}, {24'h000000, e});
   endtask

   // Watchdog well beyond the few hundred cycles the tests need
   initial begin
      #(50 * 20000);
      errors++;
      test_done();
   end

   initial begin
      aresetn = 1'b0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 3'h0;
      {s_axi_bready, s_axi_rready} = 2'h3;
      s_axi_awaddr = 8'h00;
      s_axi_araddr = 8'h00;
      s_axi_wdata = 32'h00000000;
      s_axi_wstrb = 4'hf;
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rchk(IRT_OFF_SHORT_CTRL, 8'hff, 8'h00);
      rchk(IRT_OFF_CONFIG, 8'hff, 8'h00);
      rchk(IRT_OFF_LONG_CTRL, 8'hff, 8'h00);
      rchk(IRT_OFF_PAIR_CTRL, 8'hff, 8'h1f);
      chk({31'h0, short_out}, 32'h1);
      chk({31'h0, long_out}, 32'h1);
      rd_reg(8'h3c);
      chk({30'h0, resp}, {30'h0, IRT_RESP_SLVERR});
      chk(rd, 32'h0);
      wr(8'h3c, 8'h55);
      chk({30'h0, resp}, {30'h0, IRT_RESP_SLVERR});
      $display("test reset_and_map done");
      // Forced long output merged with the idle short output (held high)
      for (int lg = 0; lg < 4; lg++) begin
         for (int f = 2; f < 4; f++) begin
            wr(IRT_OFF_CONFIG, {2'b00, 2'(lg), 2'(f), 2'b00});
            l = (f == 3);
            c = (lg == 0) ? l : (lg == 1) ? 1'b1 : (lg == 2) ? 1'b0 : !l;
            chk({31'h0, long_out}, {31'h0, l});
            chk({31'h0, comb_out}, {31'h0, c});
         end
      end
      wr(IRT_OFF_CONFIG, 8'h07);
      // Idle levels take the inverse of the new initial bits one clock after the write lands
      @(posedge aclk);
      chk({31'h0, short_out}, 32'h0);
      chk({31'h0, long_out}, 32'h0);
      wr(IRT_OFF_CONFIG, 8'h0d);
      chk({31'h0, long_out}, 32'h1);
      wr(IRT_OFF_CONFIG, 8'h00);
      $display("test transmit_outputs done");
      for (int e = 0; e < 3; e++) begin
         cfg = {2'b01, 2'(e), 4'h0};
         wr(IRT_OFF_CONFIG, cfg);
         u_pins.pulse(6, 20);
         fl = (e == 0) ? 2'b10 : (e == 1) ? 2'b01 : 2'b11;
         rchk(IRT_OFF_CONFIG, 8'h03, {6'h00, fl});
         wr(IRT_OFF_CONFIG, cfg);
         rchk(IRT_OFF_CONFIG, 8'h03, {6'h00, fl});
         wr(IRT_OFF_CONFIG, cfg | 8'h03);
         rchk(IRT_OFF_CONFIG, 8'h03, 8'h00);
      end
      wr(IRT_OFF_CONFIG, 8'h6c);
      u_pins.pulse(3, 20);
      rchk(IRT_OFF_CONFIG, 8'h03, 8'h00);
      u_pins.pulse(12, 20);
      rchk(IRT_OFF_CONFIG, 8'h03, 8'h03);
      $display("test edge_flags done");
      wr(IRT_OFF_LONG_RELOAD_LOW, 8'hff);
      wr(IRT_OFF_LONG_RELOAD_HIGH, 8'hff);
      wr(IRT_OFF_CONFIG, 8'h43);
      wr(IRT_OFF_LONG_CTRL, 8'h84);
      u_pins.pulse(4, 40);
      n0 = long_reqs;
      u_pins.pulse(4, 40);
      chk(long_reqs - n0, 32'h1);
      rd_reg(IRT_OFF_CAPTURE_LOW);
      cap[7:0] = rd[7:0];
      rd_reg(IRT_OFF_CAPTURE_HIGH);
      cap[15:8] = rd[7:0];
      // Rising edges 45 clocks apart: 44 decrements after the all-ones reload
      chk({16'h0, cap}, 32'h0000002c);
      rchk(IRT_OFF_CONFIG, 8'h02, 8'h02);
      wr(IRT_OFF_CONFIG, 8'h43);
      wr(IRT_OFF_LONG_CTRL, 8'h80);
      n0 = long_reqs;
      u_pins.pulse(4, 40);
      chk(long_reqs - n0, 32'h0);
      rchk(IRT_OFF_CONFIG, 8'h02, 8'h02);
      $display("test demod_capture done");
      // Alternating_submode; the write-one clear of both flags leaves the initial bits at zero
      wr(IRT_OFF_LONG_CTRL, 8'h04);
      wr(IRT_OFF_CONFIG, 8'h03);
      wr(IRT_OFF_SHORT_RELOAD, 8'h03);
      wr(IRT_OFF_LONG_RELOAD_LOW, 8'h04);
      wr(IRT_OFF_LONG_RELOAD_HIGH, 8'h00);
      n0 = long_reqs;
      n1 = short_reqs;
      wr(IRT_OFF_SHORT_CTRL, 8'h84);
      repeat (60) @(posedge aclk);
      rd_reg(IRT_OFF_PAIR_CTRL);
      chk({31'h0, rd[7] ^ rd[6]}, 32'h1);
      rchk(IRT_OFF_SHORT_CTRL, 8'h20, 8'h20);
      rchk(IRT_OFF_LONG_CTRL, 8'h20, 8'h20);
      chk({31'h0, short_reqs > n1}, 32'h1);
      chk({31'h0, long_reqs > n0}, 32'h1);
      wr(IRT_OFF_CONFIG, 8'h04);
      rd_reg(IRT_OFF_PAIR_CTRL);
      cfg = rd[7:0] & 8'hc0;
      repeat (30) @(posedge aclk);
      rchk(IRT_OFF_PAIR_CTRL, 8'hc0, cfg);
      $display("test alternating_submode done");
      // Reload of zero: counts on through the wrap with no timeout
      wr(IRT_OFF_PAIR_CTRL, 8'h00);
      wr(IRT_OFF_LONG_CTRL, 8'h00);
      wr(IRT_OFF_LONG_RELOAD_LOW, 8'h00);
      chk({31'h0, long_out}, 32'h1);
      n0 = long_reqs;
      wr(IRT_OFF_LONG_CTRL, 8'h84);
      repeat (20) @(posedge aclk);
      chk({31'h0, long_out}, 32'h0);
      rchk(IRT_OFF_LONG_CTRL, 8'h20, 8'h00);
      chk(long_reqs - n0, 32'h0);
      $display("test long_wrap done");
      test_done();
   end
endmodule
